// ---- include/cbd_pkg.sv ----
/*
 Constants for the bus-cycle decoder: addressing modes, cycle kinds,
 flag positions, vector page and prefix byte.
 Assumes a single 25 MHz clock and synchronous inputs.
*/
// Notes on behaviour
// - A free cycle lasts one bus clock and is done as a read.
// - A program fetch reads the byte after the last fetched one only within the instruction's bytes; later fetches repeat that address.
// - A vector fetch reads two bytes from the top page, high first.
// - Each push writes one byte, the first at the stack pointer address and each next one byte lower.
// - Each pop reads one byte from the stack.
// - Each operand cycle moves exactly one byte, read or write.
// - The flag register holds overflow, half-carry, mask, N, Z, C.
// - Each instruction sets, keeps or leaves undefined each flag; the decoder gives this effect for N and Z only (fx_nz).
// - Indexed modes: none, byte, word offset, and two post-increments.
// - Stack modes add a byte or word offset to the stack pointer.
// - Page-two opcodes decode only after the prefix byte.
package cbd_pkg;
	typedef enum logic [3:0] {
		CBD_INHERENT_MODE                      = 4'h0,
		CBD_IMMEDIATE_MODE                     = 4'h1,
		CBD_DIR                                = 4'h2,
		CBD_EXTENDED_MODE                      = 4'h3,
		CBD_IX                                 = 4'h4,
		CBD_INDEXED_BYTE_OFFSET                = 4'h5,
		CBD_INDEXED_WORD_OFFSET                = 4'h6,
		CBD_INDEXED_POST_INCREMENT             = 4'h7,
		CBD_INDEXED_BYTE_OFFSET_POST_INCREMENT = 4'h8,
		CBD_STACK_BYTE_OFFSET                  = 4'h9,
		CBD_STACK_WORD_OFFSET                  = 4'hA,
		CBD_REL                                = 4'hB
	} cbd_mode_t;
	// Bus cycle kinds, one per sequence slot
	typedef enum logic [2:0] {
		CBD_CY_F = 3'h0, CBD_CY_P = 3'h1, CBD_CY_R = 3'h2, CBD_CY_W = 3'h3,
		CBD_CY_S = 3'h4, CBD_CY_U = 3'h5, CBD_CY_V = 3'h6
	} cbd_cyc_t;
	// Flag effect kinds
	typedef enum logic [1:0] {
		CBD_FX_KEEP = 2'h0, CBD_FX_CALC = 2'h1, CBD_FX_UNDEF = 2'h2
	} cbd_fx_t;
	localparam logic [7:0]  CBD_PREFIX   = 8'h9E;
	localparam logic [7:0]  CBD_VEC_PAGE = 8'hFF;
	localparam logic [7:0]  CBD_FLAG_RST = 8'h68;
	localparam int          CBD_F_C = 0;
	localparam int          CBD_F_Z = 1;
	localparam int          CBD_F_N = 2;
	localparam int          CBD_F_I = 3;
	localparam int          CBD_F_H = 4;
	localparam int          CBD_F_V = 7;
	localparam int          CBD_SEQ_MAX = 11;
endpackage : cbd_pkg

// ---- design/cbd_opdec.sv ----
/*
 Combinational opcode lookup: mode, length, cycles, flag effect.
 Assumes the caller tells whether the page-two prefix preceded.
*/
`timescale 1ns/1ns
module cbd_opdec
	import cbd_pkg::*;
(
	input  wire logic [7:0] opcode,   // Opcode byte
	input  wire logic       page2,    // Prefix seen
	output cbd_mode_t       mode,     // Addressing mode
	output logic [2:0]      len,      // Bytes incl. prefix
	output logic [3:0]      cycles,   // Total cycles
	output logic            is_store, // Operand written
	output cbd_fx_t         fx_nz     // N/Z effect kind
);
	// Column-based decode of the register/memory and RMW groups
	always_comb begin
		mode = CBD_INHERENT_MODE;
		len = 3'd1;
		cycles = 4'd1;
		is_store = (opcode[3:0] == 4'h7) || (opcode[3:0] == 4'hF);
		fx_nz = CBD_FX_CALC;
		if (page2) begin
			case (opcode[7:4])
			4'h6: begin
				mode = CBD_STACK_BYTE_OFFSET;
				len = 3'd3;
				cycles = 4'd6;
			end
			4'hD: begin
				mode = CBD_STACK_WORD_OFFSET;
				len = 3'd4;
				cycles = 4'd5;
			end
			4'hE: begin
				mode = CBD_STACK_BYTE_OFFSET;
				len = 3'd3;
				cycles = 4'd4;
			end
			default: begin
				mode = CBD_IX;
				len = 3'd2;
				cycles = 4'd5;
			end
			endcase
		end else begin
			case (opcode[7:4])
			4'h2: begin
				mode = CBD_REL;
				len = 3'd2;
				cycles = 4'd3;
				fx_nz = CBD_FX_KEEP;
			end
			4'h3: begin
				mode = CBD_DIR;
				len = 3'd2;
				cycles = 4'd5;
			end
			4'h6: begin
				mode = CBD_INDEXED_BYTE_OFFSET;
				len = 3'd2;
				cycles = 4'd5;
			end
			4'h7: begin
				mode = CBD_IX;
				cycles = 4'd4;
			end
			4'hA: begin
				mode = CBD_IMMEDIATE_MODE;
				len = 3'd2;
				cycles = 4'd2;
			end
			4'hB: begin
				mode = CBD_DIR;
				len = 3'd2;
				cycles = 4'd3;
			end
			4'hC: begin
				mode = CBD_EXTENDED_MODE;
				len = 3'd3;
				cycles = 4'd4;
			end
			4'hD: begin
				mode = CBD_INDEXED_WORD_OFFSET;
				len = 3'd3;
				cycles = 4'd4;
			end
			4'hE: begin
				mode = CBD_INDEXED_BYTE_OFFSET;
				len = 3'd2;
				cycles = 4'd3;
			end
			4'hF: begin
				mode = CBD_IX;
				cycles = 4'd3;
			end
			default: fx_nz = CBD_FX_KEEP;
			endcase
			// Post-increment compare forms carry a branch offset too
			if (opcode == 8'h61) begin
				mode = CBD_INDEXED_BYTE_OFFSET_POST_INCREMENT;
				len = 3'd3;
			end
			if (opcode == 8'h71) begin
				mode = CBD_INDEXED_POST_INCREMENT;
				len = 3'd2;
				cycles = 4'd5;
			end
			// Stores through the index need no operand read
			if (opcode == 8'hF7 || opcode == 8'hFF) cycles = 4'd2;
			// Pulls: opcode fetch, one pop, then a program fetch
			if (opcode == 8'h86 || opcode == 8'h88 || opcode == 8'h8A)
				cycles = 4'd3;
			if (opcode == 8'h83) begin
				cycles = 4'd11;
				fx_nz = CBD_FX_KEEP;
			end
			if (opcode == 8'h42) fx_nz = CBD_FX_UNDEF;
		end
		// Tests write nothing back, so one cycle less than their row
		if (opcode[3:0] == 4'hD && opcode[7:4] inside {4'h3, 4'h6, 4'h7})
			cycles = cycles - 4'd1;
	end
endmodule : cbd_opdec

// ---- design/cbd_top.sv ----
/*
 Bus-cycle sequencer: fetches opcode bytes, decodes them and runs
 the bus cycle sequence, one bus cycle per clock.
 Assumes memory returns read data in the same cycle as the address.
*/
`timescale 1ns/1ns
module cbd_top
	import cbd_pkg::*;
(
	input  wire logic        clk,       // 25 MHz clock
	input  wire logic        arst_n,    // Async reset, active low
	input  wire logic [7:0]  rdata,     // Memory read data
	input  wire logic [15:0] sp_in,     // Stack pointer value
	input  wire logic [15:0] pc_start,  // Program start address
	input  wire logic        start,     // Load pc_start, taken only in S_FETCH
	input  wire logic [7:0]  flag_wr,   // New flag values
	input  wire logic [7:0]  flag_en,   // Flags to update
	output logic [15:0]      addr,      // Bus address
	output logic             rd,        // Read strobe
	output logic             wr,        // Write strobe
	output logic [7:0]       wdata,     // Write data
	output cbd_cyc_t         cyc_kind,  // Current cycle kind
	output logic [7:0]       flag_register, // Flags
	output logic [2:0]       inst_len,  // Decoded length
	output logic [3:0]       inst_cyc   // Decoded cycle count
);
	typedef enum logic [2:0] {
		S_FETCH = 3'b001, S_BODY = 3'b010, S_VEC = 3'b100
	} cbd_state_t;
	typedef struct packed {
		cbd_state_t  st;
		logic [15:0] pc;
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
		cbd_cyc_t    kind;
		logic [7:0]  flags;
		logic        page2;
		logic [3:0]  left;
		logic [2:0]  len;
		logic [3:0]  cyc;
		logic [7:0]  op;
		logic        vhi;
		logic [2:0]  bleft;
	} cbd_reg_t;
	cbd_reg_t r, next_r;
	cbd_mode_t m;
	logic [2:0] d_len;
	logic [3:0] d_cyc;
	logic d_st;
	cbd_fx_t d_fx;
	cbd_opdec u_dec (
		.opcode   (rdata),
		.page2    (r.page2),
		.mode     (m),
		.len      (d_len),
		.cycles   (d_cyc),
		.is_store (d_st),
		.fx_nz    (d_fx)
	);
	// Next-state: one bus cycle per clock, every cycle one byte
	always_comb begin
		next_r = r;
		next_r.rd = 1'b1;
		next_r.wr = 1'b0;
		// Flags only move where flag_en says they move
		next_r.flags = (r.flags & ~flag_en) | (flag_wr & flag_en);
		case (r.st)
		S_FETCH: begin
			if (start) begin
				next_r.pc = pc_start;
				next_r.addr = pc_start;
				next_r.kind = CBD_CY_P;
			end else if (rdata == CBD_PREFIX && !r.page2) begin
				next_r.page2 = 1'b1;
				next_r.pc = r.pc + 16'h0001;
				next_r.addr = r.pc + 16'h0001;
				next_r.kind = CBD_CY_P;
			end else begin
				next_r.op = rdata;
				next_r.len = d_len;
				next_r.cyc = d_cyc;
				next_r.page2 = 1'b0;
				// The prefix cycle counts as one of the instruction's
				next_r.left = d_cyc - (r.page2 ? 4'd2 : 4'd1);
				// Bytes still to step over before the next opcode
				next_r.bleft = d_len - (r.page2 ? 3'd2 : 3'd1);
				next_r.pc = r.pc + 16'h0001;
				if (d_cyc == 4'd11) begin
					next_r.st = S_VEC;
					next_r.vhi = 1'b1;
					next_r.kind = CBD_CY_S;
					next_r.addr = sp_in;
					next_r.rd = 1'b0;
					next_r.wr = 1'b1;
					// Return address is past the one-byte opcode
					next_r.wdata = next_r.pc[7:0];
				end else if (d_cyc == 4'd1) begin
					next_r.addr = r.pc + 16'h0001;
					next_r.kind = CBD_CY_P;
				end else begin
					next_r.st = S_BODY;
					if (!r.page2 && (rdata == 8'h86 || rdata == 8'h88
						|| rdata == 8'h8A)) begin
						next_r.kind = CBD_CY_U;
						next_r.addr = sp_in + 16'h0001;
					end else if (m == CBD_INHERENT_MODE) begin
						next_r.kind = CBD_CY_F;
						next_r.addr = r.pc + 16'h0001;
					end else if (d_st && m != CBD_IMMEDIATE_MODE) begin
						next_r.kind = CBD_CY_W;
						next_r.addr = r.pc + 16'h0001;
						next_r.rd = 1'b0;
						next_r.wr = 1'b1;
					end else begin
						next_r.kind = CBD_CY_R;
						next_r.addr = r.pc + 16'h0001;
					end
				end
			end
		end
		S_BODY: begin
			next_r.left = r.left - 4'd1;
			// Step only across this instruction's bytes, then wait
			if (r.bleft != 3'd0) begin
				next_r.pc = r.pc + 16'h0001;
				next_r.bleft = r.bleft - 3'd1;
			end
			next_r.addr = next_r.pc;
			next_r.kind = CBD_CY_P;
			if (r.left == 4'd1) next_r.st = S_FETCH;
		end
		S_VEC: begin
			next_r.left = r.left - 4'd1;
			if (r.left > 4'd6) begin
				next_r.kind = CBD_CY_S;
				next_r.addr = r.addr - 16'h0001;
				next_r.rd = 1'b0;
				next_r.wr = 1'b1;
				next_r.wdata = r.flags;
			end else if (r.left > 4'd4) begin
				next_r.kind = CBD_CY_V;
				next_r.addr = {CBD_VEC_PAGE, 7'h7F, ~r.vhi};
				next_r.vhi = 1'b0;
				// High byte stands on the bus while left is five
				if (r.left == 4'd5) next_r.pc[15:8] = rdata;
			end else begin
				if (r.left == 4'd4) next_r.pc[7:0] = rdata;
				next_r.kind = (r.left == 4'd4) ? CBD_CY_F : CBD_CY_P;
				next_r.addr = next_r.pc;
				if (r.left == 4'd1) next_r.st = S_FETCH;
			end
		end
		default: next_r.st = S_FETCH;
		endcase
	end
	// State register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
			r.st <= S_FETCH;
			r.rd <= 1'b1;
			r.kind <= CBD_CY_P;
			r.flags <= CBD_FLAG_RST;
		end else begin
			r <= next_r;
		end
	end
	assign addr = r.addr;
	assign rd = r.rd;
	assign wr = r.wr;
	assign wdata = r.wdata;
	assign cyc_kind = r.kind;
	assign flag_register = r.flags;
	assign inst_len = r.len;
	assign inst_cyc = r.cyc;

	property p_free_read;
		@(posedge clk) disable iff (!arst_n)
		r.kind == CBD_CY_F |-> r.rd && !r.wr;
	endproperty
	a_free_read: assert property (p_free_read) else $error("free not read");
	property p_fetch_seq;
		@(posedge clk) disable iff (!arst_n)
		(r.kind == CBD_CY_P && r.st == S_BODY && r.bleft != 3'd0)
			|=> r.addr == $past(r.addr) + 16'h0001;
	endproperty
	a_fetch_seq: assert property (p_fetch_seq) else $error("fetch skip");
	property p_vec_page;
		@(posedge clk) disable iff (!arst_n)
		r.kind == CBD_CY_V |-> r.addr[15:8] == CBD_VEC_PAGE;
	endproperty
	a_vec_page: assert property (p_vec_page) else $error("vector page");
	sequence s_vec_hi;
		r.kind == CBD_CY_V && r.addr[0] == 1'b0;
	endsequence
	property p_vec_order;
		@(posedge clk) disable iff (!arst_n)
		s_vec_hi |=> r.kind == CBD_CY_V && r.addr[0];
	endproperty
	a_vec_order: assert property (p_vec_order) else $error("vector order");
	property p_push_wr;
		@(posedge clk) disable iff (!arst_n)
		r.kind == CBD_CY_S |-> r.wr && !r.rd;
	endproperty
	a_push_wr: assert property (p_push_wr) else $error("push not write");
	property p_pop_rd;
		@(posedge clk) disable iff (!arst_n)
		r.kind == CBD_CY_U |-> r.rd && !r.wr;
	endproperty
	a_pop_rd: assert property (p_pop_rd) else $error("pop not read");
	property p_one_strobe;
		@(posedge clk) disable iff (!arst_n)
		!(r.rd && r.wr);
	endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("two strobes");
	property p_flag_keep;
		@(posedge clk) disable iff (!arst_n)
		flag_en == 8'h00 |=> r.flags == $past(r.flags);
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag moved");
	property p_vec_len;
		@(posedge clk) disable iff (!arst_n)
		$rose(r.st == S_VEC) |-> ##10 r.st == S_FETCH;
	endproperty
	a_vec_len: assert property (p_vec_len) else $error("swi length");
endmodule : cbd_top

// ---- sim/cbd_mem.sv ----
/*
 Memory partner for the bus-cycle decoder: program, data and stack.
 Assumes reads are combinational from addr and writes land on clk.
*/
`timescale 1ns/1ns
module cbd_mem (
	input  wire logic        clk,   // Bus clock
	input  wire logic [15:0] addr,  // Bus address
	input  wire logic        rd,    // Read strobe
	input  wire logic        wr,    // Write strobe
	input  wire logic [7:0]  wdata, // Write data
	output logic [7:0]       rdata  // Read data
);
	logic [7:0] bytes [0:65535];
	logic [7:0] last;
	// Filled with one-byte no-ops; vector points at 0x1234
	initial begin
		for (int i = 0; i < 65536; i++) bytes[i] = 8'h9D;
		bytes[16'hFFFE] = 8'h12;
		bytes[16'hFFFF] = 8'h34;
		last = 8'h00;
	end
	// Released bus shows the inverse, so a stale byte never matches
	assign rdata = rd ? bytes[addr] : ~last;
	always @(posedge clk) begin
		if (wr) bytes[addr] <= wdata;
		if (rd) last <= bytes[addr];
	end
endmodule : cbd_mem

// ---- sim/cpu_bus_cycle_decoder_test.sv ----
/*
 Self-checking bench for the bus-cycle decoder with a memory model.
 Assumes read data is returned in the cycle that shows the address.
*/
`timescale 1ns/1ns
module cpu_bus_cycle_decoder_test;
	import cbd_pkg::*;
	typedef struct {
		logic [15:0] code;
		logic [2:0]  len;
		logic [3:0]  cyc;
	} cbd_row_t;
	logic        clk, arst_n, start, rd, wr;
	logic [7:0]  rdata, wdata, flag_wr, flag_en, flag_register;
	logic [15:0] sp_in, pc_start, addr;
	logic [2:0]  inst_len;
	logic [3:0]  inst_cyc;
	cbd_cyc_t    cyc_kind;
	int          n_mismatch, cmp_count;
	// Prefix 00 means a page-one opcode
	cbd_row_t rows [14] = '{
		'{16'h009D, 3'h1, 4'h1}, '{16'h00A6, 3'h2, 4'h2},
		'{16'h00B6, 3'h2, 4'h3}, '{16'h00C6, 3'h3, 4'h4},
		'{16'h00D6, 3'h3, 4'h4}, '{16'h00E6, 3'h2, 4'h3},
		'{16'h00F6, 3'h1, 4'h3}, '{16'h0071, 3'h2, 4'h5},
		'{16'h0061, 3'h3, 4'h5}, '{16'h006D, 3'h2, 4'h4},
		'{16'h9E6D, 3'h3, 4'h5}, '{16'h9EE7, 3'h3, 4'h4},
		'{16'h9ED7, 3'h4, 4'h5}, '{16'h0086, 3'h1, 4'h3}};
	cbd_cyc_t kinds [10] = '{CBD_CY_S, CBD_CY_S, CBD_CY_S, CBD_CY_S,
		CBD_CY_S, CBD_CY_V, CBD_CY_V, CBD_CY_F, CBD_CY_P, CBD_CY_P};
	cbd_top dut (.clk(clk), .arst_n(arst_n), .rdata(rdata), .sp_in(sp_in),
		.pc_start(pc_start), .start(start), .flag_wr(flag_wr),
		.flag_en(flag_en), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
		.cyc_kind(cyc_kind), .flag_register(flag_register),
		.inst_len(inst_len), .inst_cyc(inst_cyc));
	cbd_mem mem (.clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
		.rdata(rdata));
	// 40 ns period
	always #20 clk = ~clk;
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out;
		if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : close_out
	// Pulse start; the fetch at pc stands from the edge that takes it
	task automatic go(input logic [15:0] pc);
		@(posedge clk) pc_start <= pc;
		start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		#1 check("fetch_addr", addr, pc);
		check("fetch_kind", 16'(cyc_kind), 16'(CBD_CY_P));
	endtask : go
	task automatic reset_values;
		check("rst_addr", addr, 16'h0000);
		check("rst_strobes", 16'({rd, wr}), 16'h0002);
		check("rst_kind", 16'(cyc_kind), 16'(CBD_CY_P));
		check("rst_flags", 16'(flag_register), 16'h0068);
	endtask : reset_values
	// Free cycles read, and no cycle both reads and writes
	always @(posedge clk) if (arst_n) begin
		#1;
		check("one_strobe", 16'(rd & wr), 16'h0000);
		if (cyc_kind === CBD_CY_F) check("free_rd", 16'({rd, wr}), 16'h0002);
		// Pops read one byte just above the stack pointer
		if (cyc_kind === CBD_CY_U) begin
			check("pop_rd", 16'({rd, wr}), 16'h0002);
			check("pop_addr", addr, sp_in + 16'h0001);
		end
	end
	// Bus cycles stay well under this; a hang ends the run here
	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end
	initial begin
		clk = 1'b0; arst_n = 1'b0; start = 1'b0; sp_in = 16'h00FF;
		pc_start = 16'h0000; flag_wr = 8'h00; flag_en = 8'h00;
		n_mismatch = 0; cmp_count = 0;
		repeat (12) @(posedge clk);
		#1 reset_values();
		@(posedge clk) arst_n <= 1'b1;
		// Table of opcodes: length and cycle count per mode
		foreach (rows[i]) begin
			logic [15:0] pc;
			pc = 16'h0400 + 16'(i * 16);
			if (rows[i].code[15:8] != 8'h00) begin
				mem.bytes[pc] = rows[i].code[15:8];
				mem.bytes[pc + 16'h0001] = rows[i].code[7:0];
			end else mem.bytes[pc] = rows[i].code[7:0];
			go(pc);
			repeat (rows[i].cyc) @(posedge clk);
			#1 check("next_fetch", addr, pc + 16'(rows[i].len));
			check("inst_len", 16'(inst_len), 16'(rows[i].len));
			check("inst_cyc", 16'(inst_cyc), 16'(rows[i].cyc));
		end
		// Sequential fetches through no-ops
		go(16'h0600);
		for (int k = 1; k < 5; k++) begin
			@(posedge clk) #1;
			check("seq_fetch", addr, 16'h0600 + 16'(k));
		end
		// Software interrupt: pushes, vector high then low
		mem.bytes[16'h0300] = 8'h83;
		go(16'h0300);
		for (int k = 0; k < 10; k++) begin
			@(posedge clk) #1;
			check("swi_kind", 16'(cyc_kind), 16'(kinds[k]));
			if (k < 5) begin
				check("push_addr", addr, 16'h00FF - 16'(k));
				check("push_strobe", 16'({rd, wr}), 16'h0001);
			end else if (k < 7) check("vec_addr", addr, 16'hFFFE + 16'(k - 5));
		end
		@(posedge clk) #1;
		check("vec_jump", addr, 16'h1234);
		check("push_pcl", 16'(mem.bytes[16'h00FF]), 16'h0001);
		// Flags: set or clear where enabled, kept elsewhere
		@(posedge clk) flag_en <= 8'h97;
		flag_wr <= 8'h95;
		@(posedge clk) flag_en <= 8'h00;
		flag_wr <= 8'hFF;
		repeat (2) @(posedge clk);
		#1 check("flags_set", 16'(flag_register), 16'h00FD);
		@(posedge clk) flag_en <= 8'h18;
		flag_wr <= 8'h00;
		@(posedge clk) flag_en <= 8'h00;
		repeat (2) @(posedge clk);
		#1 check("flags_clr", 16'(flag_register), 16'h00E5);
		// Reset again in mid-instruction
		go(16'h0300);
		repeat (2) @(posedge clk);
		arst_n <= 1'b0;
		#5 reset_values();
		@(posedge clk) arst_n <= 1'b1;
		go(16'h0400);
		close_out();
	end
endmodule : cpu_bus_cycle_decoder_test
